// ===== core/ssm_top.sv
// Synchronous serial port control register and I2C master engine.
// Assumes an Avalon-MM master on clk_i and open-drain SDA/SCL outside.
`timescale 1ns/1ps
module ssm_top (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Avalon-MM slave
  input  wire logic [7:0] avs_address_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]     avs_readdata_o,
  output logic            avs_waitrequest_o,
  // I2C pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Pin routing and SPI side
  output logic            port_owns_pins_o,
  output logic            spi_clk_idle_o,
  output logic            ss_is_gpio_o,
  // Port events
  output logic            port_interrupt_flag_o,
  input  wire logic       slave_tx_busy_i,
  input  wire logic       spi_byte_in_i
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_START = 4'b0001,
    ST_RS1   = 4'b0010,
    ST_BITLO = 4'b0011,
    ST_BITHI = 4'b0100,
    ST_ACKLO = 4'b0101,
    ST_ACKHI = 4'b0110,
    ST_STOP1 = 4'b0111,
    ST_STOP2 = 4'b1000,
    ST_HOLD  = 4'b1001
  } ssm_state_t;

  logic [7:0] sync_serial_control_ff;
  logic [7:0] second_control_register_ff;
  logic [7:0] shift_buffer_ff;
  logic [7:0] shift_register_ff;
  logic [7:0] reload_value_register_ff;
  logic       buf_full_ff;
  logic       port_interrupt_flag_ff;
  logic       rx_mode_ff;
  logic [3:0] bit_cnt_ff;
  ssm_state_t state_ff;
  ssm_pkg::ssm_i2c_drv_t drv_ff;
  logic       ack_done_ff;
  logic       wait_ff;
  logic [1:0] scl_rel_ff;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       tick;
  logic       brg_load;
  logic       brg_run;
  ssm_pkg::ssm_mode_t mode;
  logic       master_on;
  logic       bus_busy;
  logic       acc;
  logic       wr_ctrl, wr_ctrl2, wr_buf, wr_rel, wr_flags, rd_buf;
  logic       buf_ok;
  logic       write_collision_flag_set, ov_set, sif_set;
  logic       rx_done;

  ssm_pin_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pin_i   ({scl_i, sda_i}),
    .pin_o   (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  assign mode      = ssm_pkg::ssm_decode(sync_serial_control_ff[3:0]);
  assign master_on = sync_serial_control_ff[ssm_pkg::BIT_EN] && (mode.i2c_master || mode.fw_master);
  assign bus_busy  = (state_ff != ST_IDLE) && (state_ff != ST_HOLD);

  // Bus slave: one wait cycle on every access, answered in the next
  always_ff @(posedge clk_i) begin
    if (reset_i) wait_ff <= 1'b0;
    else wait_ff <= (avs_read_i || avs_write_i) && !wait_ff;
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !wait_ff;
  assign acc      = wait_ff;
  assign wr_ctrl  = acc && avs_write_i && avs_address_i == ssm_pkg::ADDR_CTRL;
  assign wr_ctrl2 = acc && avs_write_i && avs_address_i == ssm_pkg::ADDR_CTRL2;
  assign wr_buf   = acc && avs_write_i && avs_address_i == ssm_pkg::ADDR_BUF;
  assign wr_rel   = acc && avs_write_i && avs_address_i == ssm_pkg::ADDR_RELOAD;
  assign wr_flags = acc && avs_write_i && avs_address_i == ssm_pkg::ADDR_FLAGS;
  assign rd_buf   = acc && avs_read_i && avs_address_i == ssm_pkg::ADDR_BUF;

  // Buffer write is accepted in master mode only when parked in ST_HOLD; in other modes unless a slave transmit is busy
  assign buf_ok = master_on ? (state_ff == ST_HOLD)
                            : !((mode.i2c_slave || mode.spi_slave) && slave_tx_busy_i);
  assign write_collision_flag_set = wr_buf && !buf_ok;
  assign rx_done  = (state_ff == ST_BITHI) && tick && rx_mode_ff && bit_cnt_ff == 4'h7;
  assign ov_set   = (mode.spi_slave && spi_byte_in_i && buf_full_ff)  || (rx_done && buf_full_ff);

  always_ff @(posedge clk_i) begin
    if (reset_i) avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !wait_ff) begin
      unique case (avs_address_i)
        ssm_pkg::ADDR_CTRL:   avs_readdata_o <= {24'h000000, sync_serial_control_ff};
        ssm_pkg::ADDR_CTRL2:  avs_readdata_o <= {24'h000000, second_control_register_ff};
        ssm_pkg::ADDR_BUF:    avs_readdata_o <= {24'h000000, shift_buffer_ff};
        ssm_pkg::ADDR_RELOAD: avs_readdata_o <= {24'h000000, reload_value_register_ff};
        ssm_pkg::ADDR_FLAGS:  avs_readdata_o <= {28'h0000000, state_ff == ST_HOLD, bus_busy,
                                                 buf_full_ff, port_interrupt_flag_ff};
        default:              avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; hardware set wins over software write
  always_ff @(posedge clk_i) begin
    if (reset_i) sync_serial_control_ff <= ssm_pkg::CTRL_RESET;
    else begin
      if (wr_ctrl) sync_serial_control_ff <= avs_writedata_i[7:0];
      if (write_collision_flag_set) sync_serial_control_ff[ssm_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
      if (ov_set) sync_serial_control_ff[ssm_pkg::BIT_OV] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) reload_value_register_ff <= ssm_pkg::RELOAD_RESET;
    else if (wr_rel) reload_value_register_ff <= avs_writedata_i[7:0];
  end

  // Pin routing and SPI / slave pin behaviour
  assign port_owns_pins_o = sync_serial_control_ff[ssm_pkg::BIT_EN];
  assign spi_clk_idle_o   = sync_serial_control_ff[ssm_pkg::BIT_CKP];
  assign ss_is_gpio_o     = !mode.use_ss;

  // SCL released for two cycles; only then does a low level mean stretching
  always_ff @(posedge clk_i) begin
    if (reset_i) scl_rel_ff <= 2'h0;
    else scl_rel_ff <= {scl_rel_ff[0], drv_ff.scl_o};
  end

  // Generator runs while an operation is on the bus
  assign brg_load = (wr_buf && buf_ok && master_on) || !bus_busy || (tick && bus_busy)
                    || ((state_ff == ST_BITHI || state_ff == ST_ACKHI) && scl_rel_ff[1] && drv_ff.scl_o
                        && !scl_s);
  assign brg_run  = bus_busy;
  ssm_rate_gen u_brg (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .load_i   (brg_load),
    .run_i    (brg_run),
    .reload_i (reload_value_register_ff[6:0]),
    .expire_o (tick)
  );

  // Master sequencer
  always_ff @(posedge clk_i) begin
    if (reset_i || !master_on) begin
      state_ff   <= ST_IDLE;
      drv_ff     <= '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
      bit_cnt_ff <= 4'h0;
      rx_mode_ff <= 1'b0;
      shift_register_ff <= 8'h00;
      ack_done_ff <= 1'b0;
    end else begin
      ack_done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE, ST_HOLD: begin
          if (second_control_register_ff[ssm_pkg::BIT_STARTEN]) begin
            drv_ff.sda_o <= 1'b0;
            drv_ff.sda_oe <= 1'b1;
            state_ff <= ST_START;
          end else if (second_control_register_ff[ssm_pkg::BIT_RSTART] && state_ff == ST_HOLD) begin
            drv_ff.sda_o <= 1'b1;
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_RS1;
          end else if (second_control_register_ff[ssm_pkg::BIT_STOPEN] && state_ff == ST_HOLD) begin
            drv_ff.sda_o <= 1'b0;
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_STOP1;
          end else if (wr_buf && buf_ok) begin
            shift_register_ff <= avs_writedata_i[7:0];
            rx_mode_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_BITLO;
          end else if (state_ff == ST_HOLD && second_control_register_ff[ssm_pkg::BIT_RCEN]) begin
            rx_mode_ff <= 1'b1;
            bit_cnt_ff <= 4'h0;
            drv_ff.sda_o <= 1'b1;
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_BITLO;
          end else if (state_ff == ST_HOLD && second_control_register_ff[ssm_pkg::BIT_ACKEN]) begin
            drv_ff.sda_o <= second_control_register_ff[ssm_pkg::BIT_ACKDT];
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_ACKLO;
          end
        end
        ST_START, ST_RS1: if (tick) begin
          if (state_ff == ST_RS1 && drv_ff.scl_o == 1'b0) drv_ff.scl_o <= 1'b1;
          else if (state_ff == ST_RS1 && drv_ff.sda_o) drv_ff.sda_o <= 1'b0;
          else begin
            drv_ff.scl_o <= 1'b0;
            state_ff <= ST_HOLD;
          end
        end
        // SDA moves a cycle into the low phase, never together with SCL
        ST_BITLO: if (tick) begin
          drv_ff.scl_o <= 1'b1;
          state_ff <= ST_BITHI;
        end else drv_ff.sda_o <= rx_mode_ff || shift_register_ff[7];
        ST_BITHI: if (tick) begin
          shift_register_ff <= {shift_register_ff[6:0], sda_s};
          drv_ff.scl_o <= 1'b0;
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == 4'h7) begin
            if (rx_mode_ff) state_ff <= ST_HOLD;
            else state_ff <= ST_ACKLO;
          end else state_ff <= ST_BITLO;
        end
        ST_ACKLO: if (tick) begin
          drv_ff.scl_o <= 1'b1;
          state_ff <= ST_ACKHI;
        end else if (!rx_mode_ff) drv_ff.sda_o <= 1'b1;
        ST_ACKHI: if (tick) begin
          drv_ff.scl_o <= 1'b0;
          ack_done_ff <= !rx_mode_ff;
          rx_mode_ff <= 1'b0;
          state_ff <= ST_HOLD;
        end
        ST_STOP1: if (tick) begin
          drv_ff.scl_o <= 1'b1;
          state_ff <= ST_STOP2;
        end
        ST_STOP2: if (tick) begin
          drv_ff.sda_o <= 1'b1;
          drv_ff.sda_oe <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Second control register: request bits self-clear on completion
  always_ff @(posedge clk_i) begin
    if (reset_i) second_control_register_ff <= ssm_pkg::CTRL2_RESET;
    else begin
      if (wr_ctrl2) second_control_register_ff[5:0] <= avs_writedata_i[5:0];
      if (state_ff == ST_START && tick && master_on) second_control_register_ff[ssm_pkg::BIT_STARTEN] <= 1'b0;
      if (state_ff == ST_RS1 && tick && !drv_ff.sda_o) second_control_register_ff[ssm_pkg::BIT_RSTART] <= 1'b0;
      if (state_ff == ST_STOP2 && tick) second_control_register_ff[ssm_pkg::BIT_STOPEN] <= 1'b0;
      if (rx_done) second_control_register_ff[ssm_pkg::BIT_RCEN] <= 1'b0;
      if (state_ff == ST_ACKHI && tick && rx_mode_ff)
        second_control_register_ff[ssm_pkg::BIT_ACKEN] <= 1'b0;
      if (state_ff == ST_ACKHI && tick && !rx_mode_ff)
        second_control_register_ff[ssm_pkg::BIT_ACKSTAT] <= sda_s;
    end
  end

  // Receive buffer and interrupt flag; set wins over clear
  assign sif_set = (state_ff == ST_START && tick)  || (state_ff == ST_ACKHI && tick)
                   || (state_ff == ST_STOP2 && tick)  || rx_done || (state_ff == ST_RS1 && tick
                   && !drv_ff.sda_o);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shift_buffer_ff <= 8'h00;
      buf_full_ff <= 1'b0;
    end else begin
      if (wr_buf && buf_ok) shift_buffer_ff <= avs_writedata_i[7:0];
      if (rx_done && !buf_full_ff) shift_buffer_ff <= {shift_register_ff[6:0], sda_s};
      if (rx_done || ((mode.spi_master || mode.spi_slave) && spi_byte_in_i)) buf_full_ff <= 1'b1;
      else if (rd_buf) buf_full_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) port_interrupt_flag_ff <= 1'b0;
    else if (sif_set) port_interrupt_flag_ff <= 1'b1;
    else if (wr_flags && avs_writedata_i[0]) port_interrupt_flag_ff <= 1'b0;
  end
  assign port_interrupt_flag_o = port_interrupt_flag_ff;

  // Open-drain drive; slave mode stretches SCL while release bit is low
  always_comb begin
    scl_o    = 1'b0;
    sda_o    = 1'b0;
    sda_oe_o = master_on && drv_ff.sda_oe && !drv_ff.sda_o;
    scl_oe_o = master_on ? (state_ff != ST_IDLE && !drv_ff.scl_o)
                         : (sync_serial_control_ff[ssm_pkg::BIT_EN] && mode.i2c_slave
                            && !sync_serial_control_ff[ssm_pkg::BIT_CKP]);
  end

  property p_write_collision_flag;
    @(posedge clk_i) disable iff (reset_i) (write_collision_flag_set && !reset_i) |=> sync_serial_control_ff[7];
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag not set");
  property p_drop;
    @(posedge clk_i) disable iff (reset_i) (wr_buf && master_on && state_ff == ST_START) |=> state_ff != ST_BITLO;
  endproperty
  a_drop: assert property (p_drop) else $error("write not dropped during start");
  property p_ov;
    @(posedge clk_i) disable iff (reset_i) (rx_done && buf_full_ff) |=> sync_serial_control_ff[6];
  endproperty
  a_ov: assert property (p_ov) else $error("overflow not flagged");
  property p_stretch;
    @(posedge clk_i) disable iff (reset_i) (!master_on && mode.i2c_slave && sync_serial_control_ff[5]
      && !sync_serial_control_ff[4]) |-> scl_oe_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("SCL not stretched");
  property p_start_flag;
    @(posedge clk_i) disable iff (reset_i) (state_ff == ST_START && tick) |=> port_interrupt_flag_ff
      && !second_control_register_ff[0];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start completion missing");
  property p_ackstat;
    @(posedge clk_i) disable iff (reset_i) (state_ff == ST_ACKHI && tick && !rx_mode_ff && master_on)
      |=> second_control_register_ff[6] == $past(sda_s) && state_ff == ST_HOLD;
  endproperty
  a_ackstat: assert property (p_ackstat) else $error("acknowledge not stored");
  property p_stop;
    @(posedge clk_i) disable iff (reset_i) (state_ff == ST_STOP2 && tick && master_on) |=> state_ff == ST_IDLE
      && !sda_oe_o && port_interrupt_flag_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop incomplete");
  property p_route;
    @(posedge clk_i) disable iff (reset_i) !sync_serial_control_ff[5] |-> !scl_oe_o && !sda_oe_o;
  endproperty
  a_route: assert property (p_route) else $error("pins driven while disabled");
  c_start: cover property (@(posedge clk_i) disable iff (reset_i) state_ff == ST_START ##[1:400] state_ff == ST_HOLD);
  c_byte: cover property (@(posedge clk_i) disable iff (reset_i) ack_done_ff);
  c_stop: cover property (@(posedge clk_i) disable iff (reset_i) state_ff == ST_STOP2 ##1 state_ff == ST_IDLE);
endmodule : ssm_top

// ===== pkg/ssm_pkg.sv
// Constants and types for the synchronous serial port with I2C master engine.
// Assumes a single 10 MHz clock and an Avalon-MM register slave.
// Contract
// - Master: shift buffer write while bus not ready sets write collision flag.
// - Slave: buffer write during transmit sets write collision; software clears.
// - SPI: byte arrives with unread buffer sets overflow; master never does.
// - I2C: byte received with unread buffer sets overflow; software clears.
// - Port enable routes serial pins to the port, else general I/O.
// - SPI clock idles at the clock polarity bit level.
// - I2C slave holds SCL low while release bit is zero; master ignores it.
// - Codes 0000-0011 select SPI master at osc/4, /16, /64, timer two/2.
// - 0100 SPI slave with select; 0101 SPI slave without select.
// - 0110/0111 I2C slave 7/10-bit, 1000 I2C master; others reserved.
// - 1011, 1110, 1111 select software-driven master variants.
// - Enabled master accepts start, restart, write, stop, receive, acknowledge.
// - Buffer write before start completes is dropped and sets collision.
// - Master generates SCL and start/stop; repeated start keeps bus held.
// - Transmit sends address byte then data bytes, sampling acknowledge each.
// - Receive takes 8 bits, then drives the acknowledge bit.
// - Start request sets interrupt flag and waits start time first.
// - Slave acknowledge stored in bit 6 of control two; flag after ninth clock.
// - Stop request generates stop and raises flag when complete.
// - Generator loads low 7 reload bits on buffer write; stops, SCL holds.
// - Generator counts down to zero, two per instruction cycle, reload on SCL high.
// - SCL rate is oscillator over four times reload plus one.
package ssm_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_CTRL2  = 8'h18;
  localparam logic [7:0] ADDR_BUF    = 8'h1C;
  localparam logic [7:0] ADDR_RELOAD = 8'h20;
  localparam logic [7:0] ADDR_FLAGS  = 8'h24;
  localparam logic [7:0] ADDR_PINS   = 8'h28;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CTRL2_RESET  = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam int BIT_WRITE_COLLISION_FLAG = 7;
  localparam int BIT_OV   = 6;
  localparam int BIT_EN   = 5;
  localparam int BIT_CKP  = 4;
  localparam int BIT_ACKSTAT = 6;
  localparam int BIT_ACKDT   = 5;
  localparam int BIT_ACKEN   = 4;
  localparam int BIT_RCEN    = 3;
  localparam int BIT_STOPEN  = 2;
  localparam int BIT_RSTART  = 1;
  localparam int BIT_STARTEN = 0;
  // One generator tick per half instruction cycle (Q2 and Q4)
  localparam int CLK_PER_TICK = 2;
  localparam logic [3:0] MODE_SPI_M4   = 4'h0;
  localparam logic [3:0] MODE_SPI_M16  = 4'h1;
  localparam logic [3:0] MODE_SPI_M64  = 4'h2;
  localparam logic [3:0] MODE_SPI_MT2  = 4'h3;
  localparam logic [3:0] MODE_SPI_S_SS = 4'h4;
  localparam logic [3:0] MODE_SPI_S    = 4'h5;
  localparam logic [3:0] MODE_I2C_S7   = 4'h6;
  localparam logic [3:0] MODE_I2C_S10  = 4'h7;
  localparam logic [3:0] MODE_I2C_M    = 4'h8;
  localparam logic [3:0] MODE_FW_M     = 4'hB;
  localparam logic [3:0] MODE_FW_M7    = 4'hE;
  localparam logic [3:0] MODE_FW_M10   = 4'hF;

  typedef struct packed {
    logic       spi_master;
    logic       spi_slave;
    logic       use_ss;
    logic       i2c_slave;
    logic       i2c_master;
    logic       fw_master;
    logic       reserved;
  } ssm_mode_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ssm_i2c_drv_t;

  function automatic ssm_mode_t ssm_decode(input logic [3:0] m);
    ssm_mode_t d;
    d = '0;
    d.spi_master = (m <= MODE_SPI_MT2);
    d.spi_slave  = (m == MODE_SPI_S_SS) || (m == MODE_SPI_S);
    d.use_ss     = (m == MODE_SPI_S_SS);
    d.i2c_slave  = (m == MODE_I2C_S7) || (m == MODE_I2C_S10);
    d.i2c_master = (m == MODE_I2C_M);
    d.fw_master  = (m == MODE_FW_M) || (m == MODE_FW_M7) || (m == MODE_FW_M10);
    d.reserved   = !(d.spi_master | d.spi_slave | d.i2c_slave | d.i2c_master | d.fw_master);
    return d;
  endfunction : ssm_decode
endpackage : ssm_pkg

// ===== core/ssm_rate_gen.sv
// Down-counting SCL rate generator, two decrements per instruction cycle.
// Assumes reload and controls come from the same clock domain.
`timescale 1ns/1ps
module ssm_rate_gen (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       load_i,
  input  wire logic       run_i,
  input  wire logic [6:0] reload_i,
  // Status
  output logic            expire_o
);
  logic [6:0] cnt_ff;
  logic       ph_ff;

  // Phase toggle stands in for Q2/Q4
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i) ph_ff <= 1'b0;
    else ph_ff <= ~ph_ff;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) cnt_ff <= 7'h00;
    else if (load_i) cnt_ff <= reload_i;
    else if (run_i && ph_ff && cnt_ff != 7'h00) cnt_ff <= cnt_ff - 7'h01;
  end

  assign expire_o = run_i && ph_ff && cnt_ff == 7'h00;

  property p_hold_zero;
    @(posedge clk_i) disable iff (reset_i) (cnt_ff == 7'h00 && !load_i) |=> cnt_ff == 7'h00;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("generator left zero without reload");
endmodule : ssm_rate_gen

// ===== core/ssm_pin_sync.sv
// Two-flop synchroniser for the SDA and SCL pin levels.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
module ssm_pin_sync (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Pins
  input  wire logic [1:0] pin_i,
  output logic      [1:0] pin_o
);
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_ff <= 2'h3;
      s2_ff <= 2'h3;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
    end
  end
  assign pin_o = s2_ff;
endmodule : ssm_pin_sync

// ===== verif/ssm_i2c_slave_model.sv
// Behavioural I2C slave device on the two-wire bus.
// Assumes pulled-up lines; it only ever pulls SDA low, never SCL.
`timescale 1ns/1ps
module ssm_i2c_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter logic [7:0] RD_BYTE  = 8'hC5
) (
  // Bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  output logic            sda_oe_o,
  // Observation
  output logic [7:0]      last_byte_o,
  output logic            got_stop_o
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  initial begin
    sda_oe_o = 1'b0;
    last_byte_o = 8'h00;
    got_stop_o = 1'b0;
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 4'h0;
    first = 1'b1;
    rd = 1'b0;
    got_stop_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) got_stop_o = 1'b1;
  always @(posedge scl_i) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda_i};
    cnt = cnt + 4'h1;
  end
  // Data changes only while SCL is low
  always @(negedge scl_i) begin
    if (cnt == 4'h8 && !(rd && !first)) begin
      last_byte_o = sh;
      sda_oe_o = !nack_i && (!first || sh[7:1] == DEV_ADDR);
      if (first) rd = sh[0];
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      first = 1'b0;
      sda_oe_o = rd && !RD_BYTE[7];
    end else if (rd && !first) begin
      sda_oe_o = (cnt < 4'h8) && !RD_BYTE[3'h7 - cnt[2:0]];
    end
  end
endmodule : ssm_i2c_slave_model

// ===== verif/ssm_top_tb_top.sv
// Self-checking bench for the serial port control and I2C master engine.
// Assumes an open-drain bus with pull-ups and one slave model on it.
`timescale 1ns/1ps
module ssm_top_tb_top;
  localparam logic [7:0] AC = ssm_pkg::ADDR_CTRL;
  localparam logic [7:0] A2 = ssm_pkg::ADDR_CTRL2;
  localparam logic [7:0] AB = ssm_pkg::ADDR_BUF;
  localparam logic [7:0] AF = ssm_pkg::ADDR_FLAGS;
  logic        clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0]  avs_address_i, last_byte;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        scl_oe_o, sda_oe_o, owns, idle, ss_gpio, slave_tx_busy_i, spi_byte_in_i;
  logic        nack, mdl_sda_oe, got_stop, irq;
  int          n_errors = 0;
  int          samples_checked = 0;
  wire         scl_w = !scl_oe_o;
  wire         sda_w = !(sda_oe_o || mdl_sda_oe);
  ssm_top ssm_top_i (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_w),
    .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o),
    .port_owns_pins_o(owns), .spi_clk_idle_o(idle), .ss_is_gpio_o(ss_gpio),
    .port_interrupt_flag_o(irq), .slave_tx_busy_i(slave_tx_busy_i), .spi_byte_in_i(spi_byte_in_i));
  ssm_i2c_slave_model ssm_i2c_slave_model_i (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .sda_oe_o(mdl_sda_oe), .last_byte_o(last_byte), .got_stop_o(got_stop));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon transfer; read data are taken at the accepting edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 200);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 200) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : bus
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      bus(a, 1'b0, 32'h0);
      if (q[b] === v) return;
    end
    n_errors++;
    tally_and_finish();
  endtask : wait_bit
  task automatic start_i2c();
    bus(A2, 1'b1, 32'h01);
    wait_bit(A2, 0, 1'b0);
    bus(AF, 1'b0, 32'h0);
    chk("start flag", q[0], 1'b1);
    chk("flag pin", irq, 1'b1);
    bus(AF, 1'b1, 32'h01);
  endtask : start_i2c
  task automatic send(input logic [7:0] b, input logic ack);
    bus(AB, 1'b1, {24'h0, b});
    wait_bit(AF, 0, 1'b1);
    bus(AF, 1'b1, 32'h01);
    bus(A2, 1'b0, 32'h0);
    chk("ack status", q[6], ack);
    chk("slave byte", last_byte, b);
  endtask : send
  task automatic stop_i2c();
    bus(A2, 1'b1, 32'h04);
    wait_bit(A2, 2, 1'b0);
    bus(AF, 1'b0, 32'h0);
    chk("stop flag", q[0], 1'b1);
    chk("stop seen", got_stop, 1'b1);
    bus(AF, 1'b1, 32'h01);
  endtask : stop_i2c
  task automatic t_regs();
    bus(AC, 1'b0, 32'h0);
    chk("ctrl reset", q, 32'h0);
    bus(8'h30, 1'b1, 32'hFF);
    bus(8'h30, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(AC, 1'b1, 32'h3F);
    bus(AC, 1'b0, 32'h0);
    chk("ctrl rw", q, 32'h3F);
    chk("pins owned", owns, 1'b1);
    chk("clock idle", idle, 1'b1);
    bus(AC, 1'b1, 32'h00);
    chk("pins free", owns, 1'b0);
    chk("clock idle low", idle, 1'b0);
  endtask : t_regs
  task automatic t_modes();
    logic [3:0] m [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF};
    foreach (m[i]) begin
      bus(AC, 1'b1, {24'h0, 4'h2, m[i]});
      bus(AC, 1'b0, 32'h0);
      chk("mode", q[3:0], m[i]);
      chk("select pin", ss_gpio, m[i] != 4'h4);
    end
  endtask : t_modes
  task automatic t_i2c();
    time t0;
    bus(AC, 1'b1, 32'h28);
    bus(8'h20, 1'b1, 32'h84);
    start_i2c();
    send(8'h54, 1'b0);
    bus(AB, 1'b1, 32'hA5);
    @(posedge scl_w);
    t0 = $time;
    @(posedge scl_w);
    chk("scl period", 32'(($time - t0) / 100), 32'd20);
    wait_bit(AF, 0, 1'b1);
    bus(AF, 1'b1, 32'h01);
    stop_i2c();
    bus(A2, 1'b1, 32'h01);
    bus(AB, 1'b1, 32'h55);
    bus(AC, 1'b0, 32'h0);
    chk("collision", q[7], 1'b1);
    wait_bit(A2, 0, 1'b0);
    bus(AF, 1'b1, 32'h01);
    bus(AC, 1'b1, 32'h28);
    bus(AC, 1'b0, 32'h0);
    chk("collision cleared", q[7], 1'b0);
    send(8'h55, 1'b0);
    bus(A2, 1'b1, 32'h08);
    wait_bit(AF, 0, 1'b1);
    bus(AF, 1'b1, 32'h01);
    bus(AB, 1'b0, 32'h0);
    chk("received", q[7:0], 8'hC5);
    bus(A2, 1'b1, 32'h10);
    wait_bit(A2, 4, 1'b0);
    bus(AF, 1'b1, 32'h01);
    stop_i2c();
    nack <= 1'b1;
    start_i2c();
    send(8'h54, 1'b1);
    bus(A2, 1'b1, 32'h02);
    wait_bit(A2, 1, 1'b0);
    bus(AF, 1'b1, 32'h01);
    send(8'h54, 1'b1);
    stop_i2c();
    nack <= 1'b0;
  endtask : t_i2c
  task automatic t_spi(input logic [7:0] c, input logic ov);
    bus(AC, 1'b1, {24'h0, c});
    repeat (2) begin
      spi_byte_in_i <= 1'b1;
      @(posedge clk_i);
      spi_byte_in_i <= 1'b0;
      @(posedge clk_i);
    end
    bus(AC, 1'b0, 32'h0);
    chk("overflow", q[6], ov);
  endtask : t_spi
  initial begin
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {slave_tx_busy_i, spi_byte_in_i, nack} = '0;
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_modes();
    t_i2c();
    t_spi(8'h20, 1'b0);
    t_spi(8'h24, 1'b1);
    slave_tx_busy_i <= 1'b1;
    bus(AB, 1'b1, 32'h11);
    bus(AC, 1'b0, 32'h0);
    chk("slave collision", q[7], 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule : ssm_top_tb_top
